// file: hdl/pscu_defines.svh
`ifndef PSCU_DEFINES_SVH
`define PSCU_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PSCU_ADDR_SCM 32'h4008C020
`define PSCU_ADDR_UPDCTL 32'h4008C028
`define PSCU_ADDR_UPDPER 32'h4008C030
`define PSCU_ADDR_ISR 32'h4008C040
`define PSCU_ADDR_IMR 32'h4008C044
`define PSCU_ADDR_WPSR 32'h4008C048

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PSCU_MEMBER_LSB 0
`define PSCU_MEMBER_MSB 3
`define PSCU_POLICY_LSB 16
`define PSCU_POLICY_MSB 17
`define PSCU_TRIG_BIT 20
`define PSCU_CMPSEL_LSB 21
`define PSCU_CMPSEL_MSB 23
`define PSCU_UNLOCK_BIT 0
`define PSCU_WRITE_READY_FLAG_BIT 0
`define PSCU_UPDONE_BIT 1
`define PSCU_SOFTWP_BIT 0
`define PSCU_HARDWP_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PSCU_SCM_RESET 32'h00000000
`define PSCU_PER_RESET 8'h00
`define PSCU_IRQ_RESET 2'h0

`endif

// file: hdl/pscu_period_counter.sv
`timescale 1ns/10ps
module pscu_period_counter #(parameter int PW = 8) (
  input wire logic clk,
  input wire logic rstn,
  pscu_period_if.counter pif
);
  import pscu_pkg::*;

  // ----------------------------------------
  // Counts PWM periods up to the update period
  // ----------------------------------------
  logic [PW-1:0] count;
  logic reached;
  logic [PW-1:0] next_count;
  logic elapsed;

  assign reached = pif.periodStart && (count >= pif.period);
  assign next_count = reached ? '0 : (pif.periodStart ? count + 1'b1 : count);
  assign pif.elapsed = elapsed;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      elapsed <= 1'b0;
    end else begin
      count <= next_count;
      elapsed <= reached;
    end
  end

  a_elapsed_cause: assert property (@(posedge clk) disable iff (!rstn)
    elapsed |-> $past(pif.periodStart))
    else $error("Update period elapsed without a period start");

endmodule // pscu_period_counter

// file: hdl/pscu_period_if.sv
`timescale 1ns/10ps
interface pscu_period_if #(parameter int PW = 8);
  logic periodStart;
  logic [PW-1:0] period;
  logic elapsed;
  modport owner (output periodStart, output period, input elapsed);
  modport counter (input periodStart, input period, output elapsed);
endinterface // pscu_period_if

// file: hdl/pscu_pkg.sv
package pscu_pkg;

  typedef enum logic [1:0] {
    MANUAL_WRITE_MANUAL_UPDATE = 2'h0,
    MANUAL_WRITE_AUTO_UPDATE = 2'h1,
    DMA_WRITE_AUTO_UPDATE = 2'h2,
    POLICY_RESERVED = 2'h3
  } pscu_policy_t;

  typedef enum logic {
    UPD_IDLE,
    UPD_WAIT
  } pscu_state_t;

endpackage

// file: hdl/pscu_sync_update.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "pscu_defines.svh"
module pscu_sync_update #(
  parameter int PW = 8,
  parameter int NCMP = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  input wire logic periodStart,
  input wire logic [NCMP-1:0] cmpMatch,
  input wire logic hwProtect,
  input wire logic dmaDone,
  output logic [3:0] channelGroupMember,
  output pscu_pkg::pscu_policy_t groupUpdatePolicy,
  output logic applyUpdate,
  output logic dmaReq,
  output logic irq
);
  import pscu_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] syncChannelsMode;
  logic updateUnlock;
  logic [PW-1:0] updatePeriod;
  logic [1:0] intStatus;
  logic [1:0] intMask;
  logic softProtect;
  logic hardProtect;
  pscu_state_t state;
  pscu_state_t next_state;
  logic [31:0] next_rdData;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire selScm = (addr == `PSCU_ADDR_SCM);
  wire selCtl = (addr == `PSCU_ADDR_UPDCTL);
  wire selPer = (addr == `PSCU_ADDR_UPDPER);
  wire selIsr = (addr == `PSCU_ADDR_ISR);
  wire selImr = (addr == `PSCU_ADDR_IMR);
  wire selWp = (addr == `PSCU_ADDR_WPSR);
  wire writeOpen = !softProtect && !hardProtect;
  wire wrScm = wrStb && selScm && writeOpen;
  wire wrUnlock = wrStb && selCtl && wrData[`PSCU_UNLOCK_BIT];
  wire rdIsr = rdStb && selIsr;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  wire [1:0] policyBits = syncChannelsMode[`PSCU_POLICY_MSB:`PSCU_POLICY_LSB];
  wire dmaRequestTriggerSelect = syncChannelsMode[`PSCU_TRIG_BIT];
  wire [2:0] requestComparisonSelect =
    syncChannelsMode[`PSCU_CMPSEL_MSB:`PSCU_CMPSEL_LSB];
  wire policyAuto = (policyBits == 2'h1);
  wire policyDma = (policyBits == 2'h2);
  wire policyManual = !policyAuto && !policyDma;

  // ----------------------------------------
  // Update period counter
  // ----------------------------------------
  pscu_period_if #(.PW(PW)) pif ();
  assign pif.periodStart = periodStart;
  assign pif.period = updatePeriod;

  pscu_period_counter #(.PW(PW)) u_counter (
    .clk(clk),
    .rstn(rstn),
    .pif(pif)
  );

  // ----------------------------------------
  // Write-ready and DMA request causes
  // ----------------------------------------
  wire cmpHit = (32'(requestComparisonSelect) < NCMP) &&
    cmpMatch[requestComparisonSelect];
  wire dmaCause = dmaRequestTriggerSelect ? cmpHit : pif.elapsed;
  wire dmaSet = policyDma && dmaCause;
  wire wrdySet = (policyAuto && pif.elapsed) || dmaSet;
  wire autoApply = (policyAuto || policyDma) && pif.elapsed;
  wire manualApply = policyManual && (state == UPD_WAIT) && periodStart;
  wire applyNow = autoApply || manualApply;
  wire [1:0] eventSet = {applyNow, wrdySet};

  // ----------------------------------------
  // Manual update sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      UPD_IDLE: begin
        if (wrUnlock && policyManual) begin
          next_state = UPD_WAIT;
        end
      end
      UPD_WAIT: begin
        if (!policyManual || periodStart) begin
          next_state = UPD_IDLE;
        end
      end
      default: begin
        next_state = UPD_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    next_rdData = 32'h00000000;
    if (rdStb) begin
      if (selScm) begin
        next_rdData = syncChannelsMode;
      end else if (selCtl) begin
        next_rdData = {31'h00000000, updateUnlock};
      end else if (selPer) begin
        next_rdData = 32'(updatePeriod);
      end else if (selIsr) begin
        next_rdData = {30'h00000000, intStatus};
      end else if (selImr) begin
        next_rdData = {30'h00000000, intMask};
      end else if (selWp) begin
        next_rdData = {30'h00000000, hardProtect, softProtect};
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncChannelsMode <= `PSCU_SCM_RESET;
      updatePeriod <= PW'(`PSCU_PER_RESET);
      intMask <= `PSCU_IRQ_RESET;
      softProtect <= 1'b0;
      hardProtect <= 1'b0;
      rdData <= 32'h00000000;
    end else begin
      if (wrScm) begin
        syncChannelsMode <= wrData & 32'h00F3000F;
      end
      if (wrStb && selPer) begin
        updatePeriod <= wrData[PW-1:0];
      end
      if (wrStb && selImr) begin
        intMask <= wrData[1:0];
      end
      if (wrStb && selWp) begin
        softProtect <= wrData[`PSCU_SOFTWP_BIT];
      end
      hardProtect <= hwProtect;
      rdData <= next_rdData;
    end
  end

  // ----------------------------------------
  // Update control and events
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= UPD_IDLE;
      updateUnlock <= 1'b0;
      applyUpdate <= 1'b0;
      dmaReq <= 1'b0;
      intStatus <= `PSCU_IRQ_RESET;
    end else begin
      state <= next_state;
      if (manualApply || !policyManual) begin
        updateUnlock <= 1'b0;
      end else if (wrUnlock) begin
        updateUnlock <= 1'b1;
      end
      applyUpdate <= applyNow;
      if (dmaSet) begin
        dmaReq <= 1'b1;
      end else if (dmaDone || !policyDma) begin
        dmaReq <= 1'b0;
      end
      intStatus <= (rdIsr ? 2'h0 : intStatus) | eventSet;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channelGroupMember <= 4'h0;
      groupUpdatePolicy <= MANUAL_WRITE_MANUAL_UPDATE;
      irq <= 1'b0;
    end else begin
      channelGroupMember <= syncChannelsMode[`PSCU_MEMBER_MSB:`PSCU_MEMBER_LSB];
      groupUpdatePolicy <= pscu_policy_t'(policyBits);
      irq <= |(((rdIsr ? 2'h0 : intStatus) | eventSet) & intMask);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_member_follow: assert property (@(posedge clk) disable iff (!rstn)
    wrScm ##2 1'b1 |-> channelGroupMember == $past(wrData[3:0], 2))
    else $error("Group membership does not follow a write");

  a_protect_block: assert property (@(posedge clk) disable iff (!rstn)
    (wrStb && selScm && !writeOpen) |=> $stable(syncChannelsMode))
    else $error("Mode register changed while protected");

  a_manual_wait: assert property (@(posedge clk) disable iff (!rstn)
    (policyManual && !(state == UPD_WAIT && periodStart)) |=> !applyUpdate)
    else $error("Manual policy applied without unlock and period start");

  a_auto_apply: assert property (@(posedge clk) disable iff (!rstn)
    (policyAuto && pif.elapsed) |=> applyUpdate)
    else $error("Automatic policy missed an elapsed period");

  a_dma_apply: assert property (@(posedge clk) disable iff (!rstn)
    (policyDma && pif.elapsed) |=> applyUpdate)
    else $error("DMA policy missed an elapsed period");

  a_unlock_apply: assert property (@(posedge clk) disable iff (!rstn)
    (policyManual && updateUnlock && periodStart && state == UPD_WAIT)
    |=> applyUpdate && !updateUnlock)
    else $error("Unlocked update not applied at period start");

  a_apply_cause: assert property (@(posedge clk) disable iff (!rstn)
    applyUpdate |-> $past(pif.elapsed) || $past(periodStart))
    else $error("Update applied with no cause");

  a_manual_quiet: assert property (@(posedge clk) disable iff (!rstn)
    policyManual && $past(policyManual) |-> !dmaReq && !$past(wrdySet))
    else $error("Manual policy raised a request or write-ready");

  a_auto_nodma: assert property (@(posedge clk) disable iff (!rstn)
    (policyAuto && pif.elapsed) |=> !dmaReq && intStatus[`PSCU_WRITE_READY_FLAG_BIT])
    else $error("Automatic policy request or write-ready wrong");

  a_dma_period: assert property (@(posedge clk) disable iff (!rstn)
    (policyDma && !dmaRequestTriggerSelect && pif.elapsed)
    |=> dmaReq && intStatus[`PSCU_WRITE_READY_FLAG_BIT])
    else $error("DMA request not raised on elapsed period");

  a_dma_compare: assert property (@(posedge clk) disable iff (!rstn)
    (policyDma && dmaRequestTriggerSelect && cmpHit)
    |=> dmaReq && intStatus[`PSCU_WRITE_READY_FLAG_BIT])
    else $error("DMA request not raised on comparison match");

  a_cmp_select: assert property (@(posedge clk) disable iff (!rstn)
    (policyDma && dmaRequestTriggerSelect && !cmpHit && !dmaReq && !dmaSet)
    |=> !dmaReq)
    else $error("DMA request raised by an unselected comparison");

  a_unlock_ignore: assert property (@(posedge clk) disable iff (!rstn)
    (wrUnlock && !policyManual) |=> !updateUnlock && state == UPD_IDLE)
    else $error("Unlock accepted outside manual policy");

  a_reserved_quiet: assert property (@(posedge clk) disable iff (!rstn)
    (policyBits == 2'h3) |-> !dmaSet && !wrdySet && !autoApply)
    else $error("Reserved policy raised a request or write-ready");

  a_status_clear: assert property (@(posedge clk) disable iff (!rstn)
    (rdIsr && eventSet == 2'h0) |=> intStatus == 2'h0)
    else $error("Status read did not clear the flags");

  a_dma_hold: assert property (@(posedge clk) disable iff (!rstn)
    (dmaReq && !dmaDone && policyDma) |=> dmaReq)
    else $error("DMA request dropped before completion");

endmodule // pscu_sync_update

// file: verif/pscu_dma_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// DMA controller answering update requests
// ----------------------------------------
module pscu_dma_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dmaReq,
  input wire logic slow,
  output logic dmaDone
);
  logic [2:0] cnt;
  logic busy;
  // Done pulse after a short or long delay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 3'h0;
      busy <= 1'b0;
      dmaDone <= 1'b0;
    end else begin
      dmaDone <= 1'b0;
      if (busy) begin
        if (cnt == 3'h0) begin
          dmaDone <= 1'b1;
          busy <= 1'b0;
        end else begin
          cnt <= cnt - 3'h1;
        end
      end else if (dmaReq && !dmaDone) begin
        busy <= 1'b1;
        cnt <= slow ? 3'h3 : 3'h0;
      end
    end
  end
endmodule // pscu_dma_model

// file: verif/pscu_sync_update_tb.sv
`timescale 1ns/10ps
`include "pscu_defines.svh"
module pscu_sync_update_tb;
  import pscu_pkg::*;
  logic clk, rstn, wrStb, rdStb, periodStart, hwProtect, dmaDone, slow;
  logic [31:0] addr, wrData, rdData, rnd, v, d;
  logic [7:0] cmpMatch;
  logic [3:0] channelGroupMember;
  pscu_pkg::pscu_policy_t groupUpdatePolicy;
  logic applyUpdate, dmaReq, irq, req, write_ready_flag;
  int errTotal = 0;
  int nChecks = 0;
  int nApply, sel;
  pscu_sync_update #(.PW(8), .NCMP(8)) DUT (.clk(clk), .rstn(rstn), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .periodStart(periodStart), .cmpMatch(cmpMatch), .hwProtect(hwProtect),
    .dmaDone(dmaDone), .channelGroupMember(channelGroupMember),
    .groupUpdatePolicy(groupUpdatePolicy), .applyUpdate(applyUpdate),
    .dmaReq(dmaReq), .irq(irq));
  pscu_dma_model dma (.clk(clk), .rstn(rstn), .dmaReq(dmaReq), .slow(slow),
    .dmaDone(dmaDone));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] scmExp(input logic [31:0] x);
    return x & 32'h00F3000F;
  endfunction
  task automatic close_out();
    if (errTotal == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    wrData <= x;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] x);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 x = rdData;
  endtask
  task automatic watch(input int n);
    nApply = 0;
    req = 1'b0;
    repeat (n) begin
      #1;
      if (applyUpdate === 1'b1) nApply++;
      if (dmaReq === 1'b1) req = 1'b1;
      @(posedge clk);
    end
    #1;
  endtask
  task automatic pulse(input logic isPeriod, input logic [7:0] m);
    @(posedge clk);
    if (isPeriod) periodStart <= 1'b1;
    else cmpMatch <= m;
    @(posedge clk);
    periodStart <= 1'b0;
    cmpMatch <= 8'h00;
    watch(6);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    close_out();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rstn, wrStb, rdStb, periodStart, hwProtect, slow} = 6'h00;
    addr = 32'h0;
    wrData = 32'h0;
    cmpMatch = 8'h00;
    rnd = 32'hCD3B;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`PSCU_ADDR_SCM, d);
    chk("scm reset", d, 32'h0);
    @(posedge clk);
    #1 chk("rdData idle", rdData, 32'h0);
    chk("dmaReq reset", {31'h0, dmaReq}, 32'h0);
    rd(32'h4008C0FC, d);
    chk("unmapped", d, 32'h0);
    rnd = lfsr(rnd);
    v = rnd;
    wr(`PSCU_ADDR_SCM, v);
    wr(`PSCU_ADDR_WPSR, 32'h1);
    rnd = lfsr(rnd);
    wr(`PSCU_ADDR_SCM, rnd);
    rd(`PSCU_ADDR_SCM, d);
    chk("scm soft lock", d, scmExp(v));
    wr(`PSCU_ADDR_WPSR, 32'h0);
    hwProtect <= 1'b1;
    repeat (2) @(posedge clk);
    wr(`PSCU_ADDR_SCM, rnd);
    rd(`PSCU_ADDR_SCM, d);
    chk("scm hard lock", d, scmExp(v));
    hwProtect <= 1'b0;
    repeat (2) @(posedge clk);
    wr(`PSCU_ADDR_SCM, rnd);
    wr(32'h4008C0FC, ~rnd);
    rd(`PSCU_ADDR_SCM, d);
    chk("scm open", d, scmExp(rnd));
    wr(`PSCU_ADDR_IMR, 32'h1);
    wr(`PSCU_ADDR_UPDPER, 32'h0);
    for (int p = 0; p < 4; p++) begin
      for (int t = 0; t < 2; t++) begin
        rnd = lfsr(rnd);
        v = (rnd & 32'h00E0000F) | (32'(t) << 20) | (32'(p) << 16);
        wr(`PSCU_ADDR_SCM, v);
        rd(`PSCU_ADDR_ISR, d);
        slow <= rnd[4];
        repeat (2) @(posedge clk);
        #1 chk("member", {28'h0, channelGroupMember}, {28'h0, v[3:0]});
        chk("policy", 32'(groupUpdatePolicy), 32'(p));
        write_ready_flag = (p == 1) || (p == 2 && t == 0);
        if (p == 0 || p == 3) wr(`PSCU_ADDR_UPDCTL, 32'h1);
        for (int n = 0; n < 2; n++) begin
          pulse(1'b1, 8'h00);
          chk("apply", 32'(nApply), (p == 1 || p == 2 || n == 0) ? 1 : 0);
          chk("dmaReq", {31'h0, req}, {31'h0, write_ready_flag && p == 2});
          chk("irq", {31'h0, irq}, {31'h0, write_ready_flag});
          rd(`PSCU_ADDR_ISR, d);
          chk("isr", d, {30'h0, nApply > 0, write_ready_flag});
          repeat (2) @(posedge clk);
          #1 chk("irq clear", {31'h0, irq}, 32'h0);
        end
      end
    end
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      sel = int'(rnd[2:0]);
      wr(`PSCU_ADDR_SCM, (32'(sel) << 21) | 32'h00120000);
      rd(`PSCU_ADDR_ISR, d);
      pulse(1'b0, 8'h01 << ((sel + 1) % 8));
      chk("other cmp", {31'h0, req}, 32'h0);
      pulse(1'b0, 8'h01 << sel);
      chk("sel cmp", {31'h0, req}, 32'h1);
      rd(`PSCU_ADDR_ISR, d);
      chk("isr cmp", d, 32'h1);
    end
    wr(`PSCU_ADDR_UPDPER, 32'h2);
    wr(`PSCU_ADDR_SCM, 32'h00010000);
    for (int n = 0; n < 3; n++) begin
      pulse(1'b1, 8'h00);
      chk("period apply", 32'(nApply), (n == 2) ? 1 : 0);
    end
    close_out();
  end
endmodule // pscu_sync_update_tb
